// *** adcop_consts.vh ***
// Constants shared by the converter control and readout-port logic.
// Assumes a single 200 MHz clock (mclk) and synchronous inputs.
`ifndef ADCOP_CONSTS_VH
`define ADCOP_CONSTS_VH

// Result geometry: eight channels of eighteen bits, packed channel 1 lowest.
`define ADCOP_RES_W 18
`define ADCOP_NCH 8
`define ADCOP_BANK_W 144

// Clock period and the longest conversion time, both in nanoseconds.
`define ADCOP_MCLK_PERIOD_NS 5
`define ADCOP_CONV_TIME_NS 4000
// A longest time rounds down to whole cycles.
`define ADCOP_CONV_CYC (`ADCOP_CONV_TIME_NS / `ADCOP_MCLK_PERIOD_NS)
// Last count of the conversion timer: 800 cycles counted from zero.
// It is sized to the counter so the compare never truncates a wider constant.
`define ADCOP_CONV_LAST 10'h31F
`define ADCOP_CNT_W 10

// Read strobes per channel in each mode, and the serial bit budget.
`define ADCOP_PAR_LAST_PART 7'h01
`define ADCOP_BYTE_LAST_PART 7'h02
`define ADCOP_LAST_CH 3'h7
`define ADCOP_SER_BITS_CH1 7'h12
`define ADCOP_SER_BITS_ALL 7'h48

// Pin positions on the shared output bus.
`define ADCOP_LINE_TOP 15
`define ADCOP_LINE_HBF 14
`define ADCOP_LINE_DOUT_HIGH 8
`define ADCOP_LINE_DOUT_LOW 7

`endif

// *** adcop_conv_ctrl.v ***
// Conversion sequencer: joins the two sample triggers, times the conversion
// and latches all eight results into the output bank when it ends.
// Assumes triggers are synchronous to mclk and core_result is stable at the end.
`include "adcop_consts.vh"
`default_nettype none

module adcop_conv_ctrl (
  input wire mclk,
  input wire reset,
  input wire trig_a,
  input wire trig_b,
  input wire enable,
  input wire [`ADCOP_BANK_W-1:0] core_result,
  output reg busy_reg,
  output reg [`ADCOP_BANK_W-1:0] bank_reg,
  output reg done_reg
);

  localparam [`ADCOP_CNT_W-1:0] CONV_LAST = `ADCOP_CONV_LAST;

  reg trig_a_prev_reg;
  reg trig_b_prev_reg;
  reg held_a_reg;
  reg held_b_reg;
  reg [`ADCOP_CNT_W-1:0] cnt_reg;
  wire rise_a;
  wire rise_b;
  wire got_a;
  wire got_b;

  // Each group is held on its own rising edge; conversion waits for both.
  assign rise_a = trig_a & ~trig_a_prev_reg;
  assign rise_b = trig_b & ~trig_b_prev_reg;
  assign got_a = held_a_reg | rise_a;
  assign got_b = held_b_reg | rise_b;

  // Sequencer; busy and the result bank change on the same edge so a reader
  // never sees busy low with stale results, except when a power-down abandons a conversion.
  always @(posedge mclk) begin
    if (reset) begin
      trig_a_prev_reg <= 1'b0;
      trig_b_prev_reg <= 1'b0;
      held_a_reg <= 1'b0;
      held_b_reg <= 1'b0;
      cnt_reg <= {`ADCOP_CNT_W{1'b0}};
      busy_reg <= 1'b0;
      bank_reg <= {`ADCOP_BANK_W{1'b0}};
      done_reg <= 1'b0;
    end else begin
      trig_a_prev_reg <= trig_a;
      trig_b_prev_reg <= trig_b;
      done_reg <= 1'b0;
      if (!enable) begin
        // Powering down abandons a conversion in flight.
        held_a_reg <= 1'b0;
        held_b_reg <= 1'b0;
        busy_reg <= 1'b0;
        cnt_reg <= {`ADCOP_CNT_W{1'b0}};
      end else if (busy_reg) begin
        // Trigger edges are simply not looked at while converting.
        if (cnt_reg == CONV_LAST) begin
          busy_reg <= 1'b0;
          bank_reg <= core_result;
          done_reg <= 1'b1;
          cnt_reg <= {`ADCOP_CNT_W{1'b0}};
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end else if (got_a && got_b) begin
        // Tied triggers rise together and start all eight channels at once.
        busy_reg <= 1'b1;
        held_a_reg <= 1'b0;
        held_b_reg <= 1'b0;
      end else begin
        held_a_reg <= got_a;
        held_b_reg <= got_b;
      end
    end
  end

endmodule

`default_nettype wire

// *** adcop_port.v ***
// Converter control top: power-down handling, conversion sequencing and the
// parallel, byte and serial readout port with its first-channel flag.
// Assumes all pins are synchronous to mclk; the bench resolves pin levels
// from the _out and _oe pairs. Serial clock arrives on rd_n.
`include "adcop_consts.vh"
`default_nettype none

module adcop_port (
  input wire mclk,
  input wire reset,
  input wire interface_select,
  input wire power_down_n,
  input wire span_select,
  input wire sample_trigger_a,
  input wire sample_trigger_b,
  input wire cs_n,
  input wire rd_n,
  input wire [`ADCOP_BANK_W-1:0] core_result,
  input wire [15:0] output_bus_in,
  output reg [15:0] output_bus_out,
  output reg [15:0] output_bus_oe,
  output wire busy,
  output reg first_channel_flag,
  output reg first_channel_oe,
  output reg standby,
  output reg shutdown
);

  // Returns one channel's eighteen-bit result from the packed bank.
  function [17:0] chan_word;
    input [`ADCOP_BANK_W-1:0] bank;
    input [2:0] ch;
    begin
      chan_word = bank[ch * `ADCOP_RES_W +: `ADCOP_RES_W];
    end
  endfunction

  // Parallel word for one read: upper sixteen bits, then low two bits on top.
  function [15:0] par_word;
    input [17:0] w;
    input half;
    begin
      if (!half) begin
        par_word = w[17:2];
      end else begin
        par_word = {w[1:0], 14'h0000};
      end
    end
  endfunction

  // Byte for one read; the order flips with the high-byte-first input.
  function [7:0] byte_of;
    input [17:0] w;
    input [1:0] idx;
    input hbf;
    reg [1:0] k;
    begin
      k = hbf ? idx : (2'h2 - idx);
      case (k)
        2'h0: byte_of = w[17:10];
        2'h1: byte_of = w[9:2];
        default: byte_of = {w[1:0], 6'h00};
      endcase
    end
  endfunction

  wire [`ADCOP_BANK_W-1:0] bank_w;
  wire done_w;
  wire conv_enable;
  wire top_bit_or_byte_select;
  wire high_byte_first;
  wire mode_par;
  wire mode_byte;
  wire mode_ser;
  wire strobe_n;
  wire cs_fall;
  wire read_fall;
  wire sclk_fall;
  wire busy_fall;
  wire restart;
  wire [2:0] eff_chan;
  wire [6:0] eff_part;
  wire eff_done;
  wire [17:0] word_cur;
  wire [6:0] last_part;

  reg cs_prev_reg;
  reg rd_prev_reg;
  reg strobe_prev_reg;
  reg busy_prev_reg;
  reg relock_reg;
  reg [2:0] chan_reg;
  reg [2:0] chan_next;
  reg [6:0] part_reg;
  reg [6:0] part_next;
  reg done_reg;
  reg done_next;
  reg [71:0] shift_low_reg;
  reg [71:0] shift_low_next;
  reg [71:0] shift_high_reg;
  reg [71:0] shift_high_next;
  reg [15:0] bus_next;
  reg [15:0] oe_next;
  reg flag_next;

  // Mode pins: the top two lines are strap inputs outside parallel mode.
  assign top_bit_or_byte_select = output_bus_in[`ADCOP_LINE_TOP];
  assign high_byte_first = output_bus_in[`ADCOP_LINE_HBF];
  assign mode_par = ~interface_select;
  assign mode_byte = interface_select & top_bit_or_byte_select;
  assign mode_ser = interface_select & ~top_bit_or_byte_select;

  // Edge detection on the host strobes; inputs are already synchronous.
  assign strobe_n = cs_n | rd_n;
  assign cs_fall = ~cs_n & cs_prev_reg;
  assign read_fall = ~strobe_n & strobe_prev_reg;
  assign sclk_fall = ~rd_n & rd_prev_reg & ~cs_n;
  assign busy_fall = ~busy & busy_prev_reg;

  // A new frame, or fresh results outside serial mode, rewinds the pointer to channel 1.
  assign restart = cs_fall | (busy_fall & ~mode_ser);
  assign eff_chan = restart ? 3'h0 : chan_reg;
  assign eff_part = restart ? 7'h00 : part_reg;
  assign eff_done = restart ? 1'b0 : done_reg;
  assign word_cur = chan_word(bank_w, eff_chan);
  assign last_part = mode_byte ? `ADCOP_BYTE_LAST_PART : `ADCOP_PAR_LAST_PART;

  // Conversions stay locked out after a shutdown until a reset arrives.
  assign conv_enable = power_down_n & ~relock_reg;

  adcop_conv_ctrl u_conv (
    .mclk(mclk),
    .reset(reset),
    .trig_a(sample_trigger_a),
    .trig_b(sample_trigger_b),
    .enable(conv_enable),
    .core_result(core_result),
    .busy_reg(busy),
    .bank_reg(bank_w),
    .done_reg(done_w)
  );

  // Readout path: pointer, shift registers, bus data, enables and flag.
  always @* begin
    chan_next = chan_reg;
    part_next = part_reg;
    done_next = done_reg;
    shift_low_next = shift_low_reg;
    shift_high_next = shift_high_reg;
    bus_next = output_bus_out;
    flag_next = first_channel_flag;
    oe_next = 16'h0000;
    if (restart) begin
      chan_next = 3'h0;
      part_next = 7'h00;
      done_next = 1'b0;
      flag_next = 1'b0;
    end
    if (mode_ser) begin
      // Lines change on the serial clock's falling edge so they are settled
      // at the rising edge where the host samples.
      if (cs_fall) begin
        shift_low_next = {chan_word(bank_w, 3'h0), chan_word(bank_w, 3'h1),
          chan_word(bank_w, 3'h2), chan_word(bank_w, 3'h3)};
        shift_high_next = {chan_word(bank_w, 3'h4), chan_word(bank_w, 3'h5),
          chan_word(bank_w, 3'h6), chan_word(bank_w, 3'h7)};
        flag_next = 1'b1;
      end else if (sclk_fall && !done_reg) begin
        shift_low_next = {shift_low_reg[70:0], 1'b0};
        shift_high_next = {shift_high_reg[70:0], 1'b0};
        part_next = part_reg + 7'h01;
        if (part_next == `ADCOP_SER_BITS_CH1) begin
          flag_next = 1'b0;
        end
        if (part_next == `ADCOP_SER_BITS_ALL) begin
          done_next = 1'b1;
        end
      end
      bus_next = 16'h0000;
      bus_next[`ADCOP_LINE_DOUT_LOW] = shift_low_next[71];
      bus_next[`ADCOP_LINE_DOUT_HIGH] = shift_high_next[71];
      oe_next[`ADCOP_LINE_DOUT_LOW] = ~cs_n;
      oe_next[`ADCOP_LINE_DOUT_HIGH] = ~cs_n;
    end else begin
      if (read_fall) begin
        if (eff_done) begin
          // Past channel 8 the port drives zeros and does not wrap.
          bus_next = 16'h0000;
          flag_next = 1'b0;
        end else begin
          if (mode_byte) begin
            bus_next = {8'h00, byte_of(word_cur, eff_part[1:0], high_byte_first)};
          end else begin
            bus_next = par_word(word_cur, eff_part[0]);
          end
          flag_next = (eff_chan == 3'h0);
          if (eff_part == last_part) begin
            part_next = 7'h00;
            if (eff_chan == `ADCOP_LAST_CH) begin
              done_next = 1'b1;
            end else begin
              chan_next = eff_chan + 3'h1;
            end
          end else begin
            part_next = eff_part + 7'h01;
          end
        end
      end
      if (mode_byte) begin
        // Line 8 and the strap lines are never driven here.
        oe_next[7:0] = {8{~strobe_n}};
      end else begin
        oe_next = {16{~strobe_n}};
      end
    end
  end

  // Strobe history, pointer and pin registers.
  always @(posedge mclk) begin
    if (reset) begin
      cs_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
      strobe_prev_reg <= 1'b1;
      busy_prev_reg <= 1'b0;
      chan_reg <= 3'h0;
      part_reg <= 7'h00;
      done_reg <= 1'b0;
      shift_low_reg <= 72'h000000000000000000;
      shift_high_reg <= 72'h000000000000000000;
      output_bus_out <= 16'h0000;
      output_bus_oe <= 16'h0000;
      first_channel_flag <= 1'b0;
      first_channel_oe <= 1'b0;
    end else begin
      cs_prev_reg <= cs_n;
      rd_prev_reg <= rd_n;
      strobe_prev_reg <= strobe_n;
      busy_prev_reg <= busy;
      chan_reg <= chan_next;
      part_reg <= part_next;
      done_reg <= done_next;
      shift_low_reg <= shift_low_next;
      shift_high_reg <= shift_high_next;
      output_bus_out <= bus_next;
      output_bus_oe <= oe_next;
      first_channel_flag <= flag_next;
      // The flag floats whenever the device is deselected.
      first_channel_oe <= ~cs_n;
    end
  end

  // Power-down decode. The pins act at any time, conversion or not; the
  // outputs follow one cycle later since every output is registered.
  always @(posedge mclk) begin
    if (reset) begin
      standby <= 1'b0;
      shutdown <= 1'b0;
      relock_reg <= 1'b0;
    end else begin
      standby <= ~power_down_n & span_select;
      shutdown <= ~power_down_n & ~span_select;
      if (shutdown && power_down_n) begin
        relock_reg <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** adcop_port_chk.sv ***
// Concurrent checks on the converter control top, seen only through its ports.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module adcop_port_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic interface_select,
  input wire logic power_down_n,
  input wire logic span_select,
  input wire logic sample_trigger_a,
  input wire logic sample_trigger_b,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [15:0] output_bus_in,
  input wire logic [15:0] output_bus_oe,
  input wire logic busy,
  input wire logic first_channel_flag,
  input wire logic first_channel_oe,
  input wire logic standby,
  input wire logic shutdown
);
  logic [9:0] busy_cnt_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Counts busy cycles so the high time can be checked without a long repetition.
  always @(posedge mclk) begin
    if (reset || !busy) busy_cnt_reg <= 10'h000;
    else busy_cnt_reg <= busy_cnt_reg + 10'h001;
  end

  a_busy_len: assert property ($fell(busy) && power_down_n |-> busy_cnt_reg == 10'h320)
    else $error("busy high time differs from the conversion time");
  a_busy_start: assert property (!busy && $rose(sample_trigger_a) && $rose(sample_trigger_b)
    && power_down_n |=> busy)
    else $error("busy did not rise after joint trigger");
  a_bus_float: assert property (cs_n |=> output_bus_oe == 16'h0000 && !first_channel_oe)
    else $error("data lines driven while deselected");
  a_flag_drive: assert property (!cs_n |=> first_channel_oe)
    else $error("first-channel flag not driven in frame");
  a_par_oe: assert property (!cs_n && !rd_n && !interface_select |=> output_bus_oe == 16'hFFFF)
    else $error("parallel bus not fully driven during read");
  a_line8_float: assert property (interface_select && output_bus_in[15] |=> !output_bus_oe[8])
    else $error("line 8 driven in byte mode");
  a_straps_in: assert property (interface_select |=> output_bus_oe[15:14] == 2'b00)
    else $error("strap lines driven outside parallel mode");
  a_pd_standby: assert property (!power_down_n && span_select |=> standby && !shutdown)
    else $error("standby not entered");
  a_pd_shutdown: assert property (!power_down_n && !span_select |=> shutdown && !standby)
    else $error("shutdown not entered");
  a_reset_state: assert property (disable iff (1'b0) reset |=> !busy && !first_channel_flag
    && output_bus_oe == 16'h0000)
    else $error("outputs not idle after reset");
endmodule

bind adcop_port adcop_port_chk u_chk (
  .mclk(mclk), .reset(reset), .interface_select(interface_select),
  .power_down_n(power_down_n), .span_select(span_select),
  .sample_trigger_a(sample_trigger_a), .sample_trigger_b(sample_trigger_b),
  .cs_n(cs_n), .rd_n(rd_n), .output_bus_in(output_bus_in), .output_bus_oe(output_bus_oe),
  .busy(busy), .first_channel_flag(first_channel_flag), .first_channel_oe(first_channel_oe),
  .standby(standby), .shutdown(shutdown)
);
`default_nettype wire

// *** adcop_host_model.sv ***
// Host side of the shared output bus: strap levels, tied lines and pin resolution.
// Assumes the device drives a line exactly where its enable is high.
`default_nettype none

module adcop_host_model (
  input wire logic mclk,
  input wire logic interface_select,
  input wire logic byte_mode,
  input wire logic hbf,
  input wire logic [15:0] output_bus_out,
  input wire logic [15:0] output_bus_oe,
  output logic [15:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_reg = 16'h0000;
  logic [15:0] host_en;
  logic [15:0] host_val;

  // Lines neither side drives show the inverse of their last level, so a stale value never reads as good.
  always_comb begin
    host_en = interface_select ? (byte_mode ? 16'hFE00 : 16'hFE7F) : 16'h0000;
    host_val = {byte_mode, byte_mode & hbf, 14'h0000};
    pin = (output_bus_oe & output_bus_out) | (~output_bus_oe & host_en & host_val)
      | (~output_bus_oe & ~host_en & ~last_reg);
  end

  // Remembers each line's level for the floating pattern.
  always @(posedge mclk) begin
    last_reg <= pin;
  end
endmodule
`default_nettype wire

// *** adcop_tb.sv ***
// Self-checking bench for the converter control top: conversion, all readout modes, power-down.
// Assumes the checker is bound to the top and the host model resolves the bus pins.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic interface_select = 1'b0;
  logic power_down_n = 1'b1;
  logic span_select = 1'b1;
  logic trig_a = 1'b0;
  logic trig_b = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic byte_mode = 1'b0;
  logic hbf = 1'b0;
  logic [143:0] core = 144'h0;
  logic [15:0] pin;
  wire [15:0] bus_out;
  wire [15:0] bus_oe;
  wire busy, flag, flag_oe, standby, shutdown;
  int fail_count = 0;
  int n_compared = 0;
  logic [49:0] expq[$];
  event smp;

  adcop_port u_dut (
    .mclk(mclk), .reset(reset), .interface_select(interface_select),
    .power_down_n(power_down_n), .span_select(span_select), .sample_trigger_a(trig_a),
    .sample_trigger_b(trig_b), .cs_n(cs_n), .rd_n(rd_n), .core_result(core),
    .output_bus_in(pin), .output_bus_out(bus_out), .output_bus_oe(bus_oe), .busy(busy),
    .first_channel_flag(flag), .first_channel_oe(flag_oe), .standby(standby),
    .shutdown(shutdown)
  );

  adcop_host_model u_host (
    .mclk(mclk), .interface_select(interface_select), .byte_mode(byte_mode), .hbf(hbf),
    .output_bus_out(bus_out), .output_bus_oe(bus_oe), .pin(pin)
  );

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic stall();
    fail_count++;
    print_verdict();
  endtask

  task automatic cmp_read(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD read t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_state(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD state t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Oldest expectation against the settled pins: {flag_oe, flag, float mask, drive mask, data}.
  initial begin
    logic [49:0] e;
    forever begin
      @(smp);
      e = expq.pop_front();
      cmp_read({flag_oe, e[49] ? flag : e[48], bus_oe & (e[47:32] | e[31:16]),
        bus_out & e[31:16]}, {e[49:48], e[31:16], e[15:0]});
    end
  end

  task automatic note(input logic [49:0] e);
    expq.push_back(e);
    -> smp;
  endtask

  // One read strobe; the answer is looked at two falling edges later, before release.
  task automatic rd(input logic [49:0] e);
    @(negedge mclk) rd_n = 1'b0;
    repeat (2) @(negedge mclk);
    note(e);
    rd_n = 1'b1;
  endtask

  task automatic close_frame();
    @(negedge mclk) cs_n = 1'b1;
    repeat (2) @(negedge mclk);
    note({2'b00, 32'hFFFF0000, 16'h0000});
  endtask

  // Loads fresh results, fires the triggers gap cycles apart, re-fires them while busy.
  task automatic convert(input int gap);
    int n;
    int m;
    for (int j = 0; j < 5; j++) core = {core[111:0], $urandom};
    @(negedge mclk) trig_a = 1'b1;
    repeat (gap) @(negedge mclk);
    cmp_state(16'(busy), 16'h0000);
    trig_b = 1'b1;
    n = 0;
    m = 0;
    while (busy !== 1'b1 && n < 10) @(negedge mclk) n++;
    cmp_state(16'(n), 16'h0001);
    {trig_a, trig_b} = 2'b00;
    while (busy === 1'b1 && m < 1000) begin
      @(negedge mclk) m++;
      {trig_a, trig_b} = (m == 5) ? 2'b11 : 2'b00;
    end
    if (n == 10 || m == 1000) stall();
    cmp_state(16'(m), 16'h0320);
    repeat (3) @(negedge mclk);
    cmp_state(16'(busy), 16'h0000);
  endtask

  // Mode 0 parallel, 1 byte high first, 2 byte low first; one read past channel 8.
  task automatic frame(input int mode);
    logic [17:0] r;
    logic [15:0] w;
    int np;
    np = mode ? 3 : 2;
    @(negedge mclk) {interface_select, byte_mode, hbf} = {mode != 0, mode != 0, mode == 1};
    @(negedge mclk) cs_n = 1'b0;
    for (int i = 0; i <= 8 * np; i++) begin
      r = core[18 * (i % 24 / np) +: 18];
      case (mode ? ((mode == 1) ? i % np : 2 - i % np) : 3 + i % np)
        0: w = {8'h00, r[17:10]};
        1: w = {8'h00, r[9:2]};
        2: w = {8'h00, r[1:0], 6'h00};
        3: w = r[17:2];
        default: w = {r[1:0], 14'h0000};
      endcase
      if (i == 8 * np) w = 16'h0000;
      rd({1'b1, i < np, mode ? 32'hC10000FF : 32'h0000FFFF, w});
    end
    close_frame();
  endtask

  // Serial: channels 1-4 on line 7 and 5-8 on line 8, most significant bit first.
  task automatic ser_frame();
    logic [15:0] w;
    logic [49:0] e;
    int b;
    @(negedge mclk) {interface_select, byte_mode, hbf} = 3'b100;
    @(negedge mclk) cs_n = 1'b0;
    repeat (2) @(negedge mclk);
    for (int k = 0; k <= 72; k++) begin
      b = 18 * (k / 18) + 17 - k % 18;
      w = 16'h0000;
      if (k < 72) w[8:7] = {core[b + 72], core[b]};
      e = {1'b1, k < 18, 32'hC0000180, w};
      if (k == 0) note(e);
      else rd(e);
    end
    close_frame();
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'h2DF3));
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    cmp_state({13'h0000, busy, flag, flag_oe}, 16'h0000);
    {power_down_n, span_select} = 2'b01;
    repeat (2) @(negedge mclk);
    cmp_state({14'h0000, standby, shutdown}, 16'h0002);
    power_down_n = 1'b1;
    repeat (20000) @(negedge mclk);
    {power_down_n, span_select} = 2'b00;
    repeat (2) @(negedge mclk);
    cmp_state({14'h0000, standby, shutdown}, 16'h0001);
    $display("test power_down done");
    // The long shutdown settling time is not modelled; only the reset pulse is applied.
    {power_down_n, span_select, reset} = 3'b111;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    convert(0);
    frame(0);
    $display("test parallel done");
    convert(7);
    frame(1);
    frame(2);
    $display("test byte done");
    ser_frame();
    $display("test serial done");
    // Let the monitor take the last note before the run ends.
    @(negedge mclk);
    print_verdict();
  end
endmodule
`default_nettype wire
